/* File: hdl/preset_clk_pkg.sv */
// Constants for the preset selector and baseband clock source logic.
package preset_clk_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FREQ      = 8'h04;
  localparam logic [7:0] REG_CFG       = 8'h08;
  localparam logic [7:0] REG_RATE      = 8'h0C;
  localparam logic [7:0] REG_NAME      = 8'h10;
  localparam logic [7:0] REG_CMD       = 8'h14;
  localparam logic [7:0] REG_LIST      = 8'h18;
  localparam logic [7:0] REG_LIST_FREQ = 8'h1C;
  localparam logic [7:0] REG_LIST_CFG  = 8'h20;
  localparam logic [7:0] REG_LIST_NAME = 8'h24;
  localparam logic [7:0] REG_STATUS    = 8'h28;
  localparam logic [7:0] REG_PINMAP    = 8'h2C;
  localparam logic [7:0] REG_PRESETS   = 8'h30;

  // Control register fields.
  localparam int CTRL_CLK_SRC  = 0;
  localparam int CTRL_CLK_FREE = 1;
  localparam int CTRL_RATE_AUTO = 2;
  localparam int CTRL_AUTO_CARR = 3;
  localparam int CTRL_DATA_SRC = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Command register fields.
  localparam int CMD_SAVE   = 8;
  localparam int CMD_FORMAT = 9;

  // Setup word layout.
  localparam int FREQ_W = 24;
  localparam int CFG_W  = 7;
  localparam int NAME_W = 32;
  localparam int WORD_W = FREQ_W + CFG_W + NAME_W + 1;
  localparam int CFG_RAND = 4;
  localparam int CFG_INV  = 5;
  localparam int CFG_DIFF = 6;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 24'h000000;
  localparam logic [CFG_W-1:0]  CFG_RESET  = 7'h00;
  localparam logic [FREQ_W-1:0] RATE_RESET = 24'h000000;

  // Preset selection pins and their mapping onto select bits.
  localparam int PIN_COUNT = 6;
  localparam int SEL_W     = 4;
  localparam int SLOTS     = 16;
  localparam logic [2:0] PIN_MAP [SEL_W] = '{3'h0, 3'h1, 3'h2, 3'h3};

  // RF output condition codes.
  localparam logic [1:0] RF_OFF     = 2'h0;
  localparam logic [1:0] RF_CARRIER = 2'h1;
  localparam logic [1:0] RF_MOD     = 2'h2;

  // Data activity window.
  localparam int CLK_MHZ        = 40;
  localparam int DATA_HOLD_NS   = 100000;
  localparam int DATA_HOLD_CYC  = (DATA_HOLD_NS * CLK_MHZ) / 1000;
  localparam int DATA_CNT_W     = 12;

  typedef enum logic [3:0] {
    BOOT_SAMPLE = 4'b0001,
    BOOT_FETCH  = 4'b0010,
    BOOT_APPLY  = 4'b0100,
    BOOT_RUN    = 4'b1000
  } boot_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_ACK  = 3'b100
  } bus_t;

endpackage

/* File: hdl/preset_mem_if.sv */
// Carrier between the controller and the preset store.
`timescale 1ns/100ps
interface preset_mem_if;
  import preset_clk_pkg::*;
  logic                     wrEn;
  logic [SEL_W-1:0]         wrAddr;
  logic [WORD_W-1:0]        wrData;
  logic                     format;
  logic [SEL_W-1:0]         rdAddr;
  logic [WORD_W-1:0]        rdData;
  logic [SLOTS-1:0]         validMap;

  modport ctrl  (output wrEn, wrAddr, wrData, format, rdAddr, input rdData, validMap);
  modport store (input wrEn, wrAddr, wrData, format, rdAddr, output rdData, validMap);
endinterface

/* File: hdl/preset_store.sv */
// Preset slot storage with registered read data.
`timescale 1ns/100ps
module preset_store
  import preset_clk_pkg::*;
(
  input  wire logic        mclk,
  preset_mem_if.store      mem
);

  // Slots model retained storage, so they and the valid map ignore reset.
  logic [WORD_W-1:0] slot [SLOTS];
  logic [WORD_W-1:0] rdData_q;
  logic [SLOTS-1:0]  validMap_q;

  always_ff @(posedge mclk)
  begin
    if (mem.wrEn)
    begin
      slot[mem.wrAddr] <= mem.wrData;
    end
  end

  always_ff @(posedge mclk)
  begin
    rdData_q <= slot[mem.rdAddr];
  end

  always_ff @(posedge mclk)
  begin
    if (mem.format)
    begin
      validMap_q <= 16'h0000;
    end
    else if (mem.wrEn)
    begin
      validMap_q[mem.wrAddr] <= 1'b1;
    end
  end

  assign mem.rdData   = rdData_q;
  assign mem.validMap = validMap_q;

endmodule

/* File: hdl/preset_clk_sel.sv */
// Preset pin latch, preset storage control and baseband clock source select.
//
// How it works
// - A floating (high) select pin reads as 0 and a grounded (low) pin as 1.
// - Four of the six candidate pins form the select code, and the map is readable.
// - A select code of zero runs the normal configuration from the setup registers.
// - A nonzero select code applies the stored preset with that number, 1 to 15.
// - A preset holds frequency, modulation, randomizer, inversion and differential coding.
// - The pins are sampled once after each reset and never again until the next reset.
// - A save into slot 1 to 15 with its name is accepted only under select code zero.
// - The save stores frequency, all configuration bits and the name, and the presets register reports slots 1 to 15.
// - The list index selects one slot whose name and settings are read back.
// - Internal clock source modulates from internal clock and data, ignoring all else.
// - External clock, clock-free off and auto rate derive the rate from present data.
// - In that mode without data the RF is off, or plain carrier with auto carrier set.
// - External clock, clock-free off and manual rate always modulate at the set rate.
`timescale 1ns/100ps
module preset_clk_sel
  import preset_clk_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic [7:0]            avAddress,
  input  wire logic                  avRead,
  input  wire logic                  avWrite,
  input  wire logic [31:0]           avWritedata,
  input  wire logic [3:0]            avByteenable,
  output logic [31:0]                avReaddata,
  output logic                       avWaitrequest,
  input  wire logic [PIN_COUNT-1:0]  presetPin,
  input  wire logic                  extData,
  output logic [FREQ_W-1:0]          carrierFreq,
  output logic [3:0]                 modType,
  output logic                       randomizerEn,
  output logic                       dataInvert,
  output logic                       diffEncode,
  output logic [FREQ_W-1:0]          bitRate,
  output logic [1:0]                 rfMode,
  output logic                       useInternalClk,
  output logic                       useInternalData,
  output logic                       autoRateFromData,
  output logic                       presetActive
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  function automatic logic [SEL_W-1:0] pinsToCode(input logic [PIN_COUNT-1:0] pins);
    logic [SEL_W-1:0] code;
    code = 4'h0;
    for (int i = 0; i < SEL_W; i++)
    begin
      code[i] = ~pins[PIN_MAP[i]];
    end
    return code;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  preset_mem_if mem ();

  preset_store u_store
  (
    .mclk (mclk),
    .mem  (mem.store)
  );

  boot_t                 bootState_q;
  bus_t                  busState_q;
  logic [SEL_W-1:0]      selCode_q;
  logic [4:0]            ctrl_q;
  logic [FREQ_W-1:0]     setupFreq_q;
  logic [CFG_W-1:0]      setupCfg_q;
  logic [FREQ_W-1:0]     rate_q;
  logic [NAME_W-1:0]     name_q;
  logic [SEL_W-1:0]      listIdx_q;
  logic                  saveRefused_q;
  logic                  dataPrev_q;
  logic [DATA_CNT_W-1:0] dataCnt_q;
  logic                  dataPresent_q;
  logic                  wrEn_d;
  logic                  formatEn_d;
  logic                  busWrite;
  logic [31:0]           wrWord;
  logic [31:0]           readWord;
  logic [31:0]           oldWord;
  logic [CFG_W-1:0]      listCfg;
  logic [SLOTS-1:0]      validMap;

  assign busWrite = avWrite && (busState_q == BUS_ACK);
  assign validMap = mem.validMap;
  assign listCfg  = mem.rdData[FREQ_W +: CFG_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Power-up sequence.

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bootState_q <= BOOT_SAMPLE;
    end
    else
    begin
      unique case (bootState_q)
        BOOT_SAMPLE: bootState_q <= BOOT_FETCH;
        BOOT_FETCH:  bootState_q <= BOOT_APPLY;
        BOOT_APPLY:  bootState_q <= BOOT_RUN;
        BOOT_RUN:    bootState_q <= BOOT_RUN;
        default:     bootState_q <= BOOT_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      selCode_q <= 4'h0;
    end
    else if (bootState_q == BOOT_SAMPLE)
    begin
      selCode_q <= pinsToCode(presetPin);
    end
  end

  assign mem.rdAddr = (bootState_q == BOOT_FETCH) ? selCode_q : listIdx_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      carrierFreq  <= FREQ_RESET;
      modType      <= 4'h0;
      randomizerEn <= 1'b0;
      dataInvert   <= 1'b0;
      diffEncode   <= 1'b0;
      presetActive <= 1'b0;
    end
    else if (bootState_q == BOOT_APPLY && selCode_q != 4'h0 && mem.rdData[WORD_W-1])
    begin
      carrierFreq  <= mem.rdData[FREQ_W-1:0];
      modType      <= listCfg[3:0];
      randomizerEn <= listCfg[CFG_RAND];
      dataInvert   <= listCfg[CFG_INV];
      diffEncode   <= listCfg[CFG_DIFF];
      presetActive <= 1'b1;
    end
    else if (!presetActive && bootState_q == BOOT_RUN)
    begin
      // An empty slot leaves the unit on the setup registers rather than dead.
      carrierFreq  <= setupFreq_q;
      modType      <= setupCfg_q[3:0];
      randomizerEn <= setupCfg_q[CFG_RAND];
      dataInvert   <= setupCfg_q[CFG_INV];
      diffEncode   <= setupCfg_q[CFG_DIFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave.

  // Every access takes three edges, which gives the store time to follow a new list index.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      busState_q    <= BUS_IDLE;
      avWaitrequest <= 1'b1;
      avReaddata    <= 32'h00000000;
    end
    else
    begin
      unique case (busState_q)
        BUS_IDLE:
        begin
          if ((avRead || avWrite) && bootState_q == BOOT_RUN)
          begin
            busState_q <= BUS_WAIT;
          end
        end
        BUS_WAIT:
        begin
          busState_q    <= BUS_ACK;
          avWaitrequest <= 1'b0;
          avReaddata    <= readWord;
        end
        BUS_ACK:
        begin
          busState_q    <= BUS_IDLE;
          avWaitrequest <= 1'b1;
        end
        default:
        begin
          busState_q    <= BUS_IDLE;
          avWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb
  begin
    readWord = 32'h00000000;
    unique case (avAddress)
      REG_CTRL:      readWord = {27'h0000000, ctrl_q};
      REG_FREQ:      readWord = {8'h00, setupFreq_q};
      REG_CFG:       readWord = {25'h0000000, setupCfg_q};
      REG_RATE:      readWord = {8'h00, rate_q};
      REG_NAME:      readWord = name_q;
      REG_LIST:      readWord = {28'h0000000, listIdx_q};
      REG_LIST_FREQ: readWord = {8'h00, mem.rdData[FREQ_W-1:0]};
      REG_LIST_CFG:  readWord = {mem.rdData[WORD_W-1], 24'h000000, listCfg};
      REG_LIST_NAME: readWord = mem.rdData[FREQ_W+CFG_W +: NAME_W];
      REG_STATUS:    readWord = {22'h000000, saveRefused_q, presetActive, rfMode,
                                 dataPresent_q, presetActive, selCode_q};
      REG_PINMAP:    readWord = {20'h00000, PIN_MAP[3], PIN_MAP[2], PIN_MAP[1], PIN_MAP[0]};
      REG_PRESETS:   readWord = {16'h0000, validMap[SLOTS-1:1], 1'b0};
      default:       readWord = 32'h00000000;
    endcase
  end

  always_comb
  begin
    oldWord = 32'h00000000;
    unique case (avAddress)
      REG_CTRL: oldWord = {27'h0000000, ctrl_q};
      REG_FREQ: oldWord = {8'h00, setupFreq_q};
      REG_CFG:  oldWord = {25'h0000000, setupCfg_q};
      REG_RATE: oldWord = {8'h00, rate_q};
      REG_NAME: oldWord = name_q;
      REG_LIST: oldWord = {28'h0000000, listIdx_q};
      default:  oldWord = 32'h00000000;
    endcase
    wrWord = mergeBytes(oldWord, avWritedata, avByteenable);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_q      <= CTRL_RESET;
      setupFreq_q <= FREQ_RESET;
      setupCfg_q  <= CFG_RESET;
      rate_q      <= RATE_RESET;
      name_q      <= 32'h00000000;
      listIdx_q   <= 4'h0;
    end
    else if (busWrite)
    begin
      unique case (avAddress)
        REG_CTRL: ctrl_q      <= wrWord[4:0];
        REG_FREQ: setupFreq_q <= wrWord[FREQ_W-1:0];
        REG_CFG:  setupCfg_q  <= wrWord[CFG_W-1:0];
        REG_RATE: rate_q      <= wrWord[FREQ_W-1:0];
        REG_NAME: name_q      <= wrWord;
        REG_LIST: listIdx_q   <= wrWord[SEL_W-1:0];
        default:  listIdx_q   <= listIdx_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Preset save and erase commands.

  always_comb
  begin
    wrEn_d     = 1'b0;
    formatEn_d = 1'b0;
    if (busWrite && avAddress == REG_CMD && avByteenable[1])
    begin
      formatEn_d = avWritedata[CMD_FORMAT];
      wrEn_d     = avWritedata[CMD_SAVE] && selCode_q == 4'h0 && avWritedata[3:0] != 4'h0;
    end
  end

  assign mem.wrEn   = wrEn_d;
  assign mem.format = formatEn_d;
  assign mem.wrAddr = avWritedata[SEL_W-1:0];
  assign mem.wrData = {1'b1, name_q, setupCfg_q, setupFreq_q};

  // A refusal stays visible until the next command write with the save bit set.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      saveRefused_q <= 1'b0;
    end
    else if (busWrite && avAddress == REG_CMD && avWritedata[CMD_SAVE])
    begin
      saveRefused_q <= !wrEn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // External data activity and RF condition.

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dataPrev_q    <= 1'b0;
      dataCnt_q     <= 12'h000;
      dataPresent_q <= 1'b0;
    end
    else
    begin
      dataPrev_q <= extData;
      if (extData != dataPrev_q)
      begin
        dataCnt_q     <= DATA_CNT_W'(DATA_HOLD_CYC);
        dataPresent_q <= 1'b1;
      end
      else if (dataCnt_q != 12'h000)
      begin
        dataCnt_q     <= dataCnt_q - 12'h001;
        dataPresent_q <= (dataCnt_q != 12'h001);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rfMode           <= RF_OFF;
      useInternalClk   <= 1'b0;
      useInternalData  <= 1'b0;
      autoRateFromData <= 1'b0;
      bitRate          <= RATE_RESET;
    end
    else
    begin
      bitRate          <= rate_q;
      useInternalClk   <= ctrl_q[CTRL_CLK_SRC];
      useInternalData  <= ctrl_q[CTRL_CLK_SRC] | ctrl_q[CTRL_DATA_SRC];
      autoRateFromData <= !ctrl_q[CTRL_CLK_SRC] && !ctrl_q[CTRL_CLK_FREE]
                          && ctrl_q[CTRL_RATE_AUTO] && dataPresent_q;
      if (ctrl_q[CTRL_CLK_SRC])
      begin
        rfMode <= RF_MOD;
      end
      else if (!ctrl_q[CTRL_CLK_FREE] && !ctrl_q[CTRL_RATE_AUTO])
      begin
        rfMode <= RF_MOD;
      end
      else if (dataPresent_q)
      begin
        rfMode <= RF_MOD;
      end
      else
      begin
        rfMode <= ctrl_q[CTRL_AUTO_CARR] ? RF_CARRIER : RF_OFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_PIN_POLARITY: assert property (bootState_q == BOOT_SAMPLE |=>
    selCode_q == pinsToCode($past(presetPin))) else $error("Select code misread.");

  AST_SEL_FROZEN: assert property (bootState_q == BOOT_RUN |=> $stable(selCode_q))
    else $error("Select code changed after power-up.");

  AST_NORMAL_CFG: assert property (bootState_q == BOOT_RUN && selCode_q == 4'h0 |=>
    carrierFreq == $past(setupFreq_q) && !presetActive)
    else $error("Normal configuration not followed.");

  AST_PRESET_APPLY: assert property (bootState_q == BOOT_APPLY && selCode_q != 4'h0
    && mem.rdData[WORD_W-1] |=> presetActive && carrierFreq == $past(mem.rdData[FREQ_W-1:0])
    ##1 $stable(carrierFreq)[*3]) else $error("Preset not applied or not held.");

  AST_SAVE_GATED: assert property (mem.wrEn |-> selCode_q == 4'h0
    && mem.wrAddr != 4'h0 && busState_q == BUS_ACK) else $error("Illegal preset save.");

  AST_INTERNAL: assert property (ctrl_q[CTRL_CLK_SRC] |=> rfMode == RF_MOD
    && useInternalClk && useInternalData) else $error("Internal clock not used.");

  AST_AUTO_RATE: assert property (!ctrl_q[CTRL_CLK_SRC] && !ctrl_q[CTRL_CLK_FREE]
    && ctrl_q[CTRL_RATE_AUTO] && dataPresent_q |=> autoRateFromData && rfMode == RF_MOD)
    else $error("Rate not derived from data.");

  AST_NO_DATA: assert property (!ctrl_q[CTRL_CLK_SRC] && !ctrl_q[CTRL_CLK_FREE]
    && ctrl_q[CTRL_RATE_AUTO] && !dataPresent_q |=>
    rfMode == ($past(ctrl_q[CTRL_AUTO_CARR]) ? RF_CARRIER : RF_OFF))
    else $error("Wrong RF state without data.");

  AST_MANUAL: assert property (!ctrl_q[CTRL_CLK_SRC] && !ctrl_q[CTRL_CLK_FREE]
    && !ctrl_q[CTRL_RATE_AUTO] |=> rfMode == RF_MOD && !autoRateFromData
    && bitRate == $past(rate_q)) else $error("Manual rate not honoured.");

  AST_DATA_SEEN: assert property (extData != dataPrev_q |=>
    dataPresent_q ##1 dataPresent_q) else $error("Data transition not registered.");

endmodule

/* File: tb/preset_partner.sv */
// Model of the preset switch pins and the external data source.
`timescale 1ns/100ps
module preset_partner
  import preset_clk_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic [PIN_COUNT-1:0] groundMask,
  input  wire logic                 dataRun,
  output logic      [PIN_COUNT-1:0] presetPin,
  output logic                      extData
);
  logic [2:0] divQ;

  ////////////////////////////////////////////////////////////////////////////////
  // pull-up when floating
  // An open switch leaves the pin at the pull-up level, never undriven.
  assign presetPin = ~groundMask;

  ////////////////////////////////////////////////////////////////////////////////
  // data transition source
  // When stopped the line idles at its last level, so only time can clear presence.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      divQ    <= 3'h0;
      extData <= 1'b0;
    end
    else
    begin
      divQ <= divQ + 3'h1;
      if (dataRun && divQ == 3'h7)
      begin
        extData <= ~extData;
      end
    end
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the preset selector and clock source logic.
`timescale 1ns/100ps
module tb;
  import preset_clk_pkg::*;
  logic                 mclk, srst, avRead, avWrite, avWaitrequest, extData, dataRun;
  logic [7:0]           avAddress;
  logic [31:0]          avWritedata, avReaddata, q;
  logic [3:0]           avByteenable, modType;
  logic [PIN_COUNT-1:0] presetPin, groundMask;
  logic [FREQ_W-1:0]    carrierFreq, bitRate;
  logic [1:0]           rfMode;
  logic                 randomizerEn, dataInvert, diffEncode, useInternalClk;
  logic                 useInternalData, autoRateFromData, presetActive;
  int                   n_mismatch, n_checks;

  preset_clk_sel uut (.mclk(mclk), .srst(srst), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata), .avByteenable(avByteenable),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .presetPin(presetPin),
    .extData(extData), .carrierFreq(carrierFreq), .modType(modType),
    .randomizerEn(randomizerEn), .dataInvert(dataInvert), .diffEncode(diffEncode),
    .bitRate(bitRate), .rfMode(rfMode), .useInternalClk(useInternalClk),
    .useInternalData(useInternalData), .autoRateFromData(autoRateFromData),
    .presetActive(presetActive));

  preset_partner partner (.mclk(mclk), .srst(srst), .groundMask(groundMask),
    .dataRun(dataRun), .presetPin(presetPin), .extData(extData));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task summarize;
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low.
  // Only the watchdog ends a wait that never gets its answer.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avAddress   <= a;
    avWrite     <= wr;
    avRead      <= ~wr;
    avWritedata <= d;
    do
    begin
      @(posedge mclk);
    end
    while (avWaitrequest !== 1'b0);
    q = avReaddata;
    avRead  <= 1'b0;
    avWrite <= 1'b0;
  endtask

  task doReset(input logic [PIN_COUNT-1:0] g);
    srst       <= 1'b1;
    groundMask <= g;
    dataRun    <= 1'b0;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task mode(input logic [7:0] c, input logic [1:0] expRf);
    bus(1'b1, REG_CTRL, 32'(c));
    repeat (5) @(posedge mclk);
    chk("rfMode", 32'(rfMode), 32'(expRf));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_save;
    doReset(6'h00);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("select code", 32'(q[4:0]), 32'h00);
    bus(1'b1, REG_CMD, 32'h0000_0200);
    bus(1'b1, REG_FREQ, 32'h0012_3456);
    bus(1'b1, REG_CFG, 32'h0000_0035);
    bus(1'b1, REG_NAME, 32'hA5C3_0F5A);
    repeat (4) @(posedge mclk);
    chk("carrierFreq", 32'(carrierFreq), 32'h0012_3456);
    chk("modType", 32'(modType), 32'h5);
    bus(1'b1, REG_CMD, 32'h0000_0100);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("slot zero refused", 32'(q[9]), 32'h1);
    bus(1'b1, REG_CMD, 32'h0000_0105);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("save accepted", 32'(q[9]), 32'h0);
    bus(1'b0, REG_PRESETS, 32'h0);
    chk("preset map", q & 32'h0000_FFFE, 32'h0000_0020);
    bus(1'b1, REG_LIST, 32'h0000_0005);
    bus(1'b0, REG_LIST, 32'h0);
    bus(1'b0, REG_LIST_FREQ, 32'h0);
    chk("list freq", 32'(q[23:0]), 32'h0012_3456);
    bus(1'b0, REG_LIST_CFG, 32'h0);
    chk("list cfg", 32'({q[31], q[6:0]}), 32'h0000_00B5);
    bus(1'b0, REG_LIST_NAME, 32'h0);
    chk("list name", q, 32'hA5C3_0F5A);
    bus(1'b1, 8'h44, 32'hFFFF_FFFF);
    bus(1'b0, 8'h44, 32'h0);
    chk("unmapped read", q, 32'h0);
    bus(1'b0, REG_PINMAP, 32'h0);
    chk("pin map", q, 32'h0000_0688);
    $display("Test save done");
  endtask

  task t_preset;
    // Pins 0 and 2 grounded give code 5; pin 4 is not a select bit.
    doReset(6'h15);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("preset code", 32'(q[4:0]), 32'h15);
    chk("carrierFreq", 32'(carrierFreq), 32'h0012_3456);
    chk("modType", 32'(modType), 32'h5);
    chk("cfg bits", 32'({randomizerEn, dataInvert, diffEncode}), 32'h6);
    chk("presetActive", 32'(presetActive), 32'h1);
    groundMask <= 6'h00;
    repeat (10) @(posedge mclk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("code after pin change", 32'(q[4:0]), 32'h15);
    chk("freq after pin change", 32'(carrierFreq), 32'h0012_3456);
    bus(1'b1, REG_CMD, 32'h0000_0103);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("save under preset", 32'(q[9]), 32'h1);
    bus(1'b0, REG_PRESETS, 32'h0);
    chk("map unchanged", q & 32'h0000_FFFE, 32'h0000_0020);
    $display("Test preset done");
  endtask

  task t_clock;
    doReset(6'h00);
    bus(1'b1, REG_RATE, 32'h0000_9C40);
    mode(8'h0D, RF_MOD);
    chk("internal clock", 32'(useInternalClk), 32'h1);
    chk("internal data", 32'(useInternalData), 32'h1);
    mode(8'h11, RF_MOD);
    mode(8'h00, RF_MOD);
    chk("bitRate", 32'(bitRate), 32'h0000_9C40);
    chk("auto rate off", 32'(autoRateFromData), 32'h0);
    mode(8'h04, RF_OFF);
    mode(8'h0C, RF_CARRIER);
    dataRun <= 1'b1;
    repeat (20) @(posedge mclk);
    mode(8'h04, RF_MOD);
    chk("auto rate on", 32'(autoRateFromData), 32'h1);
    chk("external clock", 32'(useInternalClk), 32'h0);
    dataRun <= 1'b0;
    repeat (3900) @(posedge mclk);
    chk("data still held", 32'(rfMode), 32'(RF_MOD));
    repeat (200) @(posedge mclk);
    chk("data timed out", 32'(rfMode), 32'(RF_OFF));
    mode(8'h0A, RF_CARRIER);
    chk("clock-free no auto rate", 32'(autoRateFromData), 32'h0);
    $display("Test clock done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch   = 0;
    n_checks     = 0;
    srst         = 1'b1;
    avRead       = 1'b0;
    avWrite      = 1'b0;
    avAddress    = 8'h00;
    avWritedata  = 32'h0;
    avByteenable = 4'hF;
    groundMask   = 6'h00;
    dataRun      = 1'b0;
    @(posedge mclk);
    t_save();
    t_preset();
    t_clock();
    summarize();
  end

  // The tests need under 6000 cycles; the margin covers slow bus answers.
  initial
  begin
    #(20000 * 25);
    n_mismatch++;
    summarize();
  end
endmodule
